// File: common/dadc_map.svh
`ifndef DADC_MAP_SVH
`define DADC_MAP_SVH
// register addresses (7-bit) and reset values
`define DADC_REG_POWER    7'h00
`define DADC_REG_CLOCK    7'h01
`define DADC_REG_FORMAT   7'h02
`define DADC_RST_POWER    8'h00
`define DADC_RST_CLOCK    8'h00
`define DADC_RST_FORMAT   8'h00
// field positions
`define DADC_POWER_MSB    1
`define DADC_POWER_LSB    0
`define DADC_DCS_BIT      0
`define DADC_FMT_MSB      1
`define DADC_FMT_LSB      0
// frame: read flag, address, data, msb first
`define DADC_RW_BIT       7
`define DADC_RW_READ      1'b1
`define DADC_LAST_BIT     3'h7
// pipeline: taps counted in encode edges
`define DADC_PIPE_DEPTH   7
`define DADC_TAP_FULL     5
`define DADC_TAP_DDR      6
// timing
`define DADC_MCLK_MHZ     20
`define DADC_TSCK_WR_NS   40
`define DADC_TSCK_RD_NS   250
`define DADC_TDO_NS       125
`define DADC_TSCK_WR_CYC  ((`DADC_TSCK_WR_NS * `DADC_MCLK_MHZ + 999) / 1000)
`define DADC_TSCK_RD_CYC  ((`DADC_TSCK_RD_NS * `DADC_MCLK_MHZ + 999) / 1000)
`define DADC_TDO_CYC      ((`DADC_TDO_NS * `DADC_MCLK_MHZ) / 1000)
`endif

// File: common/dadc_pkg.sv
`include "dadc_map.svh"
package dadc_pkg;
  typedef enum logic [1:0] {
    dadc_fmt_full     = 2'h0,
    dadc_fmt_ddr_cmos = 2'h1,
    dadc_fmt_ddr_lvds = 2'h2
  } dadc_fmt_e;

  typedef enum logic [1:0] {
    dadc_pwr_on    = 2'h0,
    dadc_pwr_nap   = 2'h1,
    dadc_pwr_sleep = 2'h3
  } dadc_pwr_e;

  typedef enum logic [1:0] {
    dadc_ph_cmd  = 2'h0,
    dadc_ph_data = 2'h1,
    dadc_ph_done = 2'h2
  } dadc_phase_e;

  typedef logic [11:0] dadc_code_t;

  typedef struct packed {
    dadc_code_t ch1;
    dadc_code_t ch2;
  } dadc_pair_s;

  typedef struct packed {
    dadc_phase_e phase;
    logic [2:0]  cnt;
    logic [7:0]  cmd;
    logic [7:0]  data;
  } dadc_frame_s;

  typedef struct packed {
    logic       strap_s1;
    logic       strap_s2;
    logic [7:0] power;
    logic [7:0] clock;
    logic [7:0] format;
    logic       wr_toggle;
  } dadc_regs_s;

  typedef struct packed {
    logic       strap_s1;
    logic       strap_s2;
    logic       pos_s1;
    logic       pos_s2;
    logic       pos_s3;
    logic       neg_s1;
    logic       neg_s2;
    logic       cs_s1;
    logic       cs_s2;
    logic       sck_s1;
    logic       sck_s2;
    logic       sdi_s1;
    logic       sdi_s2;
    logic       sdo_s1;
    logic       sdo_s2;
    logic       tog_s1;
    logic       tog_s2;
    logic       tog_s3;
    logic [7:0] cfg_power;
    logic [7:0] cfg_clock;
    logic [7:0] cfg_format;
    logic       serial_mode;
    logic       diff_encode;
    logic       dcs_enable;
    dadc_fmt_e  out_format;
    dadc_pwr_e  power_mode;
    dadc_pair_s [`DADC_PIPE_DEPTH-1:0] pipe;
    dadc_pair_s out_pair;
    logic       data_strobe;
    logic       sdo_o;
  } dadc_core_s;
endpackage : dadc_pkg

// File: common/dadc_link_if.sv
`timescale 1ns/100ps
interface dadc_link_if;
  logic [7:0] reg_power;
  logic [7:0] reg_clock;
  logic [7:0] reg_format;
  logic       wr_toggle;
  logic       sdo_oe;

  modport link (
    output reg_power,
    output reg_clock,
    output reg_format,
    output wr_toggle,
    output sdo_oe
  );

  modport core (
    input reg_power,
    input reg_clock,
    input reg_format,
    input wr_toggle,
    input sdo_oe
  );
endinterface : dadc_link_if

// File: rtl/dadc_spi_link.sv
`timescale 1ns/100ps
`include "dadc_map.svh"
module dadc_spi_link (
  input  wire logic       resetn,
  input  wire logic       spi_sck,
  input  wire logic       spi_cs_n,
  input  wire logic       spi_sdi,
  input  wire logic       prog_mode_select,
  dadc_link_if.link       lnk
);
  logic                  frame_rst_n;
  dadc_pkg::dadc_frame_s frm_reg;
  dadc_pkg::dadc_frame_s frm_next;
  dadc_pkg::dadc_regs_s  regs_reg;
  dadc_pkg::dadc_regs_s  regs_next;
  logic                  sdo_oe_reg;
  logic                  sdo_oe_next;
  logic [7:0]            rd_byte;
  logic [6:0]            addr;
  logic                  serial;
  logic                  is_read;
  logic                  last_rise;

  // sck stops outside frames, so chip select itself ends the frame
  assign frame_rst_n = resetn & ~spi_cs_n; // R15
  assign addr        = frm_reg.cmd[6:0];
  assign serial      = ~regs_reg.strap_s2;
  assign is_read     = frm_reg.cmd[`DADC_RW_BIT] == `DADC_RW_READ;
  assign last_rise   = (frm_reg.phase == dadc_pkg::dadc_ph_data) &&
                       (frm_reg.cnt == `DADC_LAST_BIT);

  always_comb begin
    case (addr)
      `DADC_REG_POWER:  rd_byte = regs_reg.power;
      `DADC_REG_CLOCK:  rd_byte = regs_reg.clock;
      `DADC_REG_FORMAT: rd_byte = regs_reg.format;
      default:          rd_byte = 8'h00;
    endcase
  end

  always_comb begin
    frm_next     = frm_reg;
    frm_next.cnt = frm_reg.cnt + 3'h1;
    case (frm_reg.phase)
      dadc_pkg::dadc_ph_cmd: begin
        frm_next.cmd = {frm_reg.cmd[6:0], spi_sdi}; // R7 R14
        if (frm_reg.cnt == `DADC_LAST_BIT) begin
          frm_next.phase = dadc_pkg::dadc_ph_data;
        end
      end
      dadc_pkg::dadc_ph_data: begin
        frm_next.data = {frm_reg.data[6:0], spi_sdi}; // R7 R14
        if (frm_reg.cnt == `DADC_LAST_BIT) begin
          frm_next.phase = dadc_pkg::dadc_ph_done;
        end
      end
      dadc_pkg::dadc_ph_done: begin
        // bits past the sixteenth are ignored
        frm_next.cnt = frm_reg.cnt;
      end
      default: begin
        frm_next.phase = dadc_pkg::dadc_ph_done;
      end
    endcase
  end

  always_comb begin
    regs_next          = regs_reg;
    regs_next.strap_s1 = prog_mode_select;
    regs_next.strap_s2 = regs_reg.strap_s1;
    // a write lands only on the sixteenth rising edge
    if (last_rise && serial && !is_read) begin // R2 R6 R14
      case (addr)
        `DADC_REG_POWER:  regs_next.power  = {frm_reg.data[6:0], spi_sdi};
        `DADC_REG_CLOCK:  regs_next.clock  = {frm_reg.data[6:0], spi_sdi};
        `DADC_REG_FORMAT: regs_next.format = {frm_reg.data[6:0], spi_sdi};
        default:          regs_next.power  = regs_reg.power;
      endcase
      regs_next.wr_toggle = ~regs_reg.wr_toggle;
    end
  end

  always_comb begin
    sdo_oe_next = sdo_oe_reg;
    case (frm_reg.phase)
      dadc_pkg::dadc_ph_cmd:  sdo_oe_next = 1'b0; // R14
      // open drain: enable pulls low for a zero bit
      dadc_pkg::dadc_ph_data: sdo_oe_next = serial && is_read &&
                                            !rd_byte[~frm_reg.cnt]; // R12 R13
      dadc_pkg::dadc_ph_done: sdo_oe_next = sdo_oe_reg;
      default:                sdo_oe_next = 1'b0;
    endcase
  end

  always_ff @(posedge spi_sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      frm_reg <= '0; // R15
    end else begin
      frm_reg <= frm_next; // R6
    end
  end

  always_ff @(posedge spi_sck or negedge resetn) begin
    if (!resetn) begin
      regs_reg <= '0;
    end else begin
      regs_reg <= regs_next;
    end
  end

  // launched on the falling edge so the host sees it a half period later
  always_ff @(negedge spi_sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      sdo_oe_reg <= 1'b0; // R15
    end else begin
      sdo_oe_reg <= sdo_oe_next; // R12
    end
  end

  assign lnk.reg_power  = regs_reg.power;
  assign lnk.reg_clock  = regs_reg.clock;
  assign lnk.reg_format = regs_reg.format;
  assign lnk.wr_toggle  = regs_reg.wr_toggle;
  assign lnk.sdo_oe     = sdo_oe_reg;
endmodule : dadc_spi_link

// File: rtl/dadc_top.sv
// What this block does
// R1 - result after 6 cycles full, 6.5 DDR
// R2 - strap low: pins form serial register port
// R3 - strap high: pins are static mode levels
// R4 - conversion starts on encode rising edge
// R5 - grounded complement means single-ended encode
// R6 - serial shifting only while chip select low
// R7 - data-in captured on serial clock rise
// R8 - parallel: chip select sets duty stabilizer
// R9 - parallel: serial clock pin selects format
// R10 - parallel: data-in and data-out set power
// R11 - host keeps clock period 40/250 ns
// R12 - readback bit launched after falling edge
// R13 - readback on open-drain data-out pin
// R14 - frame: read flag, address, eight data
// R15 - chip select high aborts frame, releases
`timescale 1ns/100ps
`include "dadc_map.svh"
module dadc_top (
  input  wire logic                 mclk,
  input  wire logic                 resetn,
  input  wire logic                 prog_mode_select,
  input  wire logic                 encode_in_pos,
  input  wire logic                 encode_in_neg,
  input  wire logic                 spi_cs_n,
  input  wire logic                 spi_sck,
  input  wire logic                 spi_sdi,
  input  wire logic                 spi_sdo_i,
  output logic                      spi_sdo_o,
  output logic                      spi_sdo_oe,
  input  wire dadc_pkg::dadc_code_t ch1_sample,
  input  wire dadc_pkg::dadc_code_t ch2_sample,
  output dadc_pkg::dadc_code_t      ch1_data,
  output dadc_pkg::dadc_code_t      ch2_data,
  output logic                      data_strobe,
  output logic                      serial_mode,
  output logic                      diff_encode,
  output logic                      dcs_enable,
  output logic [1:0]                out_format,
  output logic [1:0]                power_mode
);
  dadc_link_if           lnk ();
  dadc_pkg::dadc_core_s  core_reg;
  dadc_pkg::dadc_core_s  core_next;
  logic                  enc_rise;
  logic                  enc_fall;
  logic                  cfg_load;
  logic                  running;
  logic                  ddr;

  // serial port logic lives on the serial clock
  dadc_spi_link u_link (
    .resetn           (resetn),
    .spi_sck          (spi_sck),
    .spi_cs_n         (spi_cs_n),
    .spi_sdi          (spi_sdi),
    .prog_mode_select (prog_mode_select),
    .lnk              (lnk.link)
  );

  // unknown format codes fall back to full-rate outputs
  function automatic dadc_pkg::dadc_fmt_e fmt_decode(
    input logic [1:0] code
  );
    case (code)
      2'h1:    fmt_decode = dadc_pkg::dadc_fmt_ddr_cmos;
      2'h2:    fmt_decode = dadc_pkg::dadc_fmt_ddr_lvds;
      default: fmt_decode = dadc_pkg::dadc_fmt_full;
    endcase
  endfunction : fmt_decode

  // both nap codes map to nap; only all ones sleeps
  function automatic dadc_pkg::dadc_pwr_e pwr_decode(
    input logic [1:0] code
  );
    case (code)
      2'h0:    pwr_decode = dadc_pkg::dadc_pwr_on;
      2'h3:    pwr_decode = dadc_pkg::dadc_pwr_sleep;
      default: pwr_decode = dadc_pkg::dadc_pwr_nap;
    endcase
  endfunction : pwr_decode

  // edges are seen through the synchroniser, so encode must stay
  // well below half the core clock rate
  assign enc_rise = core_reg.pos_s2 && !core_reg.pos_s3;
  assign enc_fall = !core_reg.pos_s2 && core_reg.pos_s3;
  // register copy is safe: the next write is a full frame away
  assign cfg_load = core_reg.tog_s2 != core_reg.tog_s3;
  assign running  = core_reg.power_mode == dadc_pkg::dadc_pwr_on;
  assign ddr      = core_reg.out_format != dadc_pkg::dadc_fmt_full;

  always_comb begin
    core_next = core_reg;

    // pin synchronisers
    core_next.strap_s1 = prog_mode_select;
    core_next.strap_s2 = core_reg.strap_s1;
    core_next.pos_s1   = encode_in_pos;
    core_next.pos_s2   = core_reg.pos_s1;
    core_next.pos_s3   = core_reg.pos_s2;
    core_next.neg_s1   = encode_in_neg;
    core_next.neg_s2   = core_reg.neg_s1;
    core_next.cs_s1    = spi_cs_n;
    core_next.cs_s2    = core_reg.cs_s1;
    core_next.sck_s1   = spi_sck;
    core_next.sck_s2   = core_reg.sck_s1;
    core_next.sdi_s1   = spi_sdi;
    core_next.sdi_s2   = core_reg.sdi_s1;
    core_next.sdo_s1   = spi_sdo_i;
    core_next.sdo_s2   = core_reg.sdo_s1;
    core_next.tog_s1   = lnk.wr_toggle;
    core_next.tog_s2   = core_reg.tog_s1;
    core_next.tog_s3   = core_reg.tog_s2;

    // open drain: only ever pulls low
    core_next.sdo_o = 1'b0; // R13

    if (cfg_load) begin
      core_next.cfg_power  = lnk.reg_power;
      core_next.cfg_clock  = lnk.reg_clock;
      core_next.cfg_format = lnk.reg_format;
    end

    core_next.serial_mode = !core_reg.strap_s2; // R2 R3

    if (core_reg.serial_mode) begin
      core_next.dcs_enable = core_reg.cfg_clock[`DADC_DCS_BIT]; // R2
      core_next.out_format = fmt_decode(
        core_reg.cfg_format[`DADC_FMT_MSB:`DADC_FMT_LSB]); // R2
      core_next.power_mode = pwr_decode(
        core_reg.cfg_power[`DADC_POWER_MSB:`DADC_POWER_LSB]); // R2
    end else begin
      core_next.dcs_enable = core_reg.cs_s2; // R3 R8
      core_next.out_format = core_reg.sck_s2 ?
                             dadc_pkg::dadc_fmt_ddr_lvds :
                             dadc_pkg::dadc_fmt_full; // R3 R9
      core_next.power_mode = pwr_decode(
        {core_reg.sdi_s2, core_reg.sdo_s2}); // R3 R10
    end

    // any high level on the complement proves it is driven
    if (core_reg.neg_s2) begin
      core_next.diff_encode = 1'b1; // R5
    end

    core_next.data_strobe = 1'b0;

    // in differential mode the complement must be low at the edge
    if (enc_rise && running &&
        (!core_reg.diff_encode || !core_reg.neg_s2)) begin // R4 R5
      for (int i = `DADC_PIPE_DEPTH - 1; i > 0; i--) begin
        core_next.pipe[i] = core_reg.pipe[i-1];
      end
      core_next.pipe[0] = {ch1_sample, ch2_sample}; // R4
      if (!ddr) begin
        core_next.out_pair    = core_reg.pipe[`DADC_TAP_FULL]; // R1
        core_next.data_strobe = 1'b1;
      end
    end

    // double rate: half a cycle later, on the following low edge
    if (enc_fall && running && ddr) begin
      core_next.out_pair    = core_reg.pipe[`DADC_TAP_DDR]; // R1
      core_next.data_strobe = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      core_reg <= '0;
    end else begin
      core_reg <= core_next;
    end
  end

  assign spi_sdo_o   = core_reg.sdo_o;
  assign spi_sdo_oe  = lnk.sdo_oe; // R13
  assign ch1_data    = core_reg.out_pair.ch1;
  assign ch2_data    = core_reg.out_pair.ch2;
  assign data_strobe = core_reg.data_strobe;
  assign serial_mode = core_reg.serial_mode;
  assign diff_encode = core_reg.diff_encode;
  assign dcs_enable  = core_reg.dcs_enable;
  assign out_format  = core_reg.out_format;
  assign power_mode  = core_reg.power_mode;
endmodule : dadc_top

// File: verification/dadc_top_asserts.sv
`timescale 1ns/100ps
module dadc_top_asserts (
  input logic                 mclk,
  input logic                 resetn,
  input logic                 prog_mode_select,
  input logic                 encode_in_pos,
  input logic                 encode_in_neg,
  input logic                 spi_cs_n,
  input logic                 spi_sck,
  input logic                 spi_sdi,
  input logic                 spi_sdo_i,
  input logic                 spi_sdo_o,
  input logic                 spi_sdo_oe,
  input dadc_pkg::dadc_code_t ch1_sample,
  input dadc_pkg::dadc_code_t ch2_sample,
  input dadc_pkg::dadc_code_t ch1_data,
  input dadc_pkg::dadc_code_t ch2_data,
  input logic                 data_strobe,
  input logic                 serial_mode,
  input logic                 diff_encode,
  input logic                 dcs_enable,
  input logic [1:0]           out_format,
  input logic [1:0]           power_mode
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // samples seen at encode rises; frozen while powered down like the pipe
  logic [6:0][23:0] hist_reg;
  logic             enc_reg;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hist_reg <= '0;
      enc_reg  <= 1'b0;
    end else begin
      enc_reg <= encode_in_pos;
      if (encode_in_pos && !enc_reg && power_mode == 2'h0)
        hist_reg <= {hist_reg[5:0], ch1_sample, ch2_sample};
    end
  end
  sequence par_steady;
    prog_mode_select &&
      $stable({spi_cs_n, spi_sck, spi_sdi, spi_sdo_i});
  endsequence
  dcs_par_a: assert property (par_steady [*6] |->
    dcs_enable == spi_cs_n) else $error("stabilizer level wrong");
  fmt_par_a: assert property (par_steady [*6] |->
    out_format == (spi_sck ? 2'h2 : 2'h0)) else $error("format wrong");
  pwr_par_a: assert property (par_steady [*6] |->
    power_mode == (spi_sdi == spi_sdo_i ? {2{spi_sdi}} : 2'h1))
    else $error("power level wrong");
  // strap needs three edges after reset to reach serial_mode
  par_mode_a: assert property (prog_mode_select [*5] |->
    !serial_mode && !spi_sdo_oe) else $error("parallel mode wrong");
  ser_mode_a: assert property (!prog_mode_select [*4] |->
    serial_mode) else $error("serial mode missing");
  od_low_a: assert property (spi_sdo_o == 1'b0)
    else $error("data-out driven high");
  cs_rel_a: assert property (spi_cs_n [*2] |-> !spi_sdo_oe)
    else $error("data-out held while deselected");
  sdo_fall_a: assert property ($changed(spi_sdo_oe) |->
    !spi_sck || spi_cs_n) else $error("data-out moved on high clock");
  lat_val_a: assert property (data_strobe |->
    {ch1_data, ch2_data} == hist_reg[6]) else $error("result wrong");
  lat_half_a: assert property (data_strobe |->
    encode_in_pos == (out_format == 2'h0)) else $error("latency wrong");
  diff_det_a: assert property (encode_in_neg |-> ##[1:4]
    diff_encode) else $error("differential encode missed");
endmodule : dadc_top_asserts

// File: verification/dadc_spi_host.sv
`timescale 1ns/100ps
module dadc_spi_host (
  output logic cs_n,
  output logic sck,
  output logic sdi,
  output logic park,
  input  logic sdo
);
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    sdi  = 1'b0;
    park = 1'b1;
  end
  // reads run slow: the pulled-up data-out rises slowly
  task automatic xfer(input logic rd, input logic [6:0] a,
                      input logic [7:0] d, input int nb,
                      output logic [7:0] q);
    logic [15:0] f;
    int          h;
    f = {rd, a, d};
    h = rd ? 128 : 24;
    q = 8'h00;
    #7;
    cs_n = 1'b0;
    #(h);
    for (int i = 0; i < nb; i++) begin
      sdi = f[15 - i];
      #(h);
      sck = 1'b1;
      #(h);
      if (i >= 8) q = {q[6:0], sdo};
      sck = 1'b0;
    end
    #(h);
    cs_n = 1'b1;
    sdi = ~sdi;
  endtask : xfer
endmodule : dadc_spi_host

// File: verification/dual_adc_config_port_bench.sv
`timescale 1ns/100ps
`define CHK(g, e) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("mismatch at %0t got %h exp %h", $time, g, e); \
  end \
end
module dual_adc_config_port_bench;
  logic mclk = 1'b0, resetn = 1'b0, strap = 1'b1;
  logic enc = 1'b0, encn = 1'b0, run = 1'b0, dmode = 1'b0;
  dadc_pkg::dadc_code_t s1 = 12'h000, s2 = 12'h000, d1, d2;
  logic sdo_o, oe, stb, ser, dif, dcs, cs_n, sck, sdi, park;
  logic [1:0] fmt, pwr;
  logic [7:0] q, v, mem [3];
  int error_cnt = 0, cmp_count = 0, nstb = 0;
  logic [11:0] r1, r2;
  // samples in encode order; index 6 is due at the next strobe
  logic [6:0][23:0] smp = '0;
  wire sdo_pin = oe ? 1'b0 : park;
  wire [6:0] cfg = {ser, dif, pwr, fmt, dcs};
  dadc_top u_dut (
    .mclk             (mclk),
    .resetn           (resetn),
    .prog_mode_select (strap),
    .encode_in_pos    (enc),
    .encode_in_neg    (encn),
    .spi_cs_n         (cs_n),
    .spi_sck          (sck),
    .spi_sdi          (sdi),
    .spi_sdo_i        (sdo_pin),
    .spi_sdo_o        (sdo_o),
    .spi_sdo_oe       (oe),
    .ch1_sample       (s1),
    .ch2_sample       (s2),
    .ch1_data         (d1),
    .ch2_data         (d2),
    .data_strobe      (stb),
    .serial_mode      (ser),
    .diff_encode      (dif),
    .dcs_enable       (dcs),
    .out_format       (fmt),
    .power_mode       (pwr)
  );
  dadc_spi_host u_host (
    .cs_n (cs_n),
    .sck  (sck),
    .sdi  (sdi),
    .park (park),
    .sdo  (sdo_pin)
  );
  always #25 mclk = ~mclk;
  // encode far below mclk/2 so the two-flop sync sees every edge
  always begin
    repeat (8) @(posedge mclk);
    enc  <= run & ~enc;
    encn <= run & dmode & enc;
    if (run && !enc) begin
      r1 = 12'($urandom);
      r2 = 12'($urandom);
      s1  <= r1;
      s2  <= r2;
      smp <= {smp[5:0], r1, r2};
    end
  end
  always @(posedge mclk) begin
    if (stb === 1'b1) begin
      nstb <= nstb + 1;
      `CHK(d1, smp[6][23:12])
      `CHK(d2, smp[6][11:0])
    end
  end
  task automatic print_verdict();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  // code 2 has no power state of its own and naps
  function automatic logic [1:0] exp_pwr(input logic [1:0] c);
    return (c == 2'h2) ? 2'h1 : c;
  endfunction : exp_pwr
  // code 3 has no format of its own and runs full rate
  function automatic logic [1:0] exp_fmt(input logic [1:0] c);
    return (c == 2'h3) ? 2'h0 : c;
  endfunction : exp_fmt
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_host.xfer(1'b0, a, d, 16, q);
    repeat (10) @(posedge mclk);
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    u_host.xfer(1'b1, a, 8'h00, 16, q);
    `CHK(q, e)
    // frames must stay apart even after a read
    repeat (10) @(posedge mclk);
  endtask : rd
  task automatic burst(input logic [1:0] f);
    wr(7'h02, {6'h00, f});
    nstb = 0;
    run <= 1'b1;
    repeat (160) @(posedge mclk);
    run <= 1'b0;
    repeat (32) @(posedge mclk);
    `CHK(nstb >= 4, 1'b1)
  endtask : burst
  initial begin
    void'($urandom(82));
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      @(posedge mclk);
      u_host.cs_n <= i[0];
      u_host.sck  <= i[1];
      u_host.sdi  <= i[2];
      u_host.park <= i[3];
      repeat (8) @(posedge mclk);
      `CHK(dcs, i[0])
      `CHK(fmt, i[1] ? 2'h2 : 2'h0)
      `CHK(pwr, i[2] == i[3] ? {2{i[2]}} : 2'h1)
      `CHK(ser | oe, 1'b0)
    end
    u_host.cs_n <= 1'b1;
    u_host.sck  <= 1'b0;
    u_host.park <= 1'b1;
    resetn      <= 1'b0;
    strap       <= 1'b0;
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
    `CHK(cfg, 7'h40)
    for (int a = 0; a < 3; a++) begin
      for (int k = 0; k < 4; k++) begin
        v = {6'($urandom), k[1:0]};
        wr(7'(a), v);
        case (a)
          0: `CHK(pwr, exp_pwr(v[1:0]))
          1: `CHK(dcs, v[0])
          default: `CHK(fmt, exp_fmt(v[1:0]))
        endcase
        rd(7'(a), v);
      end
      mem[a] = v;
    end
    wr(7'h05, 8'ha5);
    rd(7'h05, 8'h00);
    u_host.xfer(1'b0, 7'h01, 8'h00, 12, q);
    repeat (10) @(posedge mclk);
    `CHK(dcs, 1'b1)
    // a port that ignored chip select would clear register 1 here
    for (int i = 0; i < 16; i++) begin
      u_host.sdi = (i == 7);
      #24 u_host.sck = 1'b1;
      #24 u_host.sck = 1'b0;
    end
    rd(7'h01, mem[1]);
    `CHK(dcs, 1'b1)
    wr(7'h00, 8'h00);
    burst(2'h0);
    burst(2'h1);
    `CHK(dif, 1'b0)
    dmode <= 1'b1;
    burst(2'h2);
    `CHK(dif, 1'b1)
    // nap: encode keeps running but nothing is sampled
    wr(7'h00, 8'h01);
    nstb = 0;
    run <= 1'b1;
    repeat (64) @(posedge mclk);
    run <= 1'b0;
    repeat (32) @(posedge mclk);
    `CHK(nstb, 0)
    print_verdict();
  end
  initial begin
    #1000000;
    error_cnt++;
    print_verdict();
  end
endmodule : dual_adc_config_port_bench
bind dadc_top dadc_top_asserts u_chk (.*);
